//--- pkg/gfl_pkg.sv
/*
 * gfl_pkg: register map, field positions, reset values and
 * enumerations shared by the four-line filtered i/o block.
 * assumes a 32-bit apb slave with one aligned word per register.
 */
package gfl_pkg;
   localparam int NLINES = 4;
   localparam int NSOFT = 4;
   localparam int SPAN_W = 16;
   localparam int CYC_W = 24;
   // clock rate in cycles per microsecond (250 mhz)
   localparam int CLK_MHZ = 250;
   localparam logic [CYC_W-1:0] CYC_PER_US = 24'h0000fa;

   // register byte offsets
   localparam logic [7:0] OFF_LINE_PICKER = 8'h00;
   localparam logic [7:0] OFF_LINE_CFG = 8'h04;
   localparam logic [7:0] OFF_LINE_STAT = 8'h08;
   localparam logic [7:0] OFF_ALL_LINES = 8'h0c;
   localparam logic [7:0] OFF_FILTER_CHOICE = 8'h10;
   localparam logic [7:0] OFF_FILTER_SPAN = 8'h14;
   localparam logic [7:0] OFF_SOFT_PICKER = 8'h18;
   localparam logic [7:0] OFF_SOFT_LEVEL = 8'h1c;
   localparam logic [7:0] OFF_SOFT_VECTOR = 8'h20;

   // line configuration field positions
   localparam int F_DIR = 0;
   localparam int F_FLIP = 1;
   localparam int F_AUX = 2;
   localparam int F_ORIGIN_LO = 4;
   localparam int F_SUB_LO = 8;
   // line status field positions
   localparam int F_LEVEL = 0;
   localparam int F_CIRCUIT_LO = 1;

   // drive origin codes
   typedef enum logic [2:0] {
      ORG_LOOPBACK = 3'h0,
      ORG_SOFT = 3'h1,
      ORG_COUNTER = 3'h2,
      ORG_LOGIC = 3'h3,
      ORG_EXPOSURE = 3'h4,
      ORG_FRAME_WAIT = 3'h5
   } gfl_origin_t;

   // circuit type codes, fixed per line
   localparam logic [1:0] CT_TRI_STATE = 2'h0;
   localparam logic [1:0] CT_OPTO = 2'h1;
   localparam logic [1:0] CT_OPEN_DRAIN = 2'h2;
   localparam logic [7:0] CIRCUIT_MAP = 8'ha0; // lines 3..0: od od tri tri
   // lines that own an auxiliary rail switch
   localparam logic [3:0] AUX_CAPABLE = 4'h4;

   // reset values
   localparam logic [2:0] ORIGIN_RST = 3'h1;
   localparam logic [SPAN_W-1:0] SPAN_RST = 16'h0000;
endpackage : gfl_pkg

//--- core/gfl_gpio.sv
/*
 * gfl_gpio: four general-purpose lines with per-line direction,
 * polarity flip, deglitch then debounce input filters, selectable
 * output drive, soft output bits and an auxiliary rail switch on line 2.
 * assumes an apb master on pclk; line pins are asynchronous and
 * the internal source signals come from logic on pclk.
 */
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps

module gfl_gpio (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // connector lines
   input wire logic [3:0] line_in,
   output logic [3:0] line_out,
   output logic [3:0] line_oe,
   output logic [3:0] aux_rail_switch,
   // internal sources on pclk
   input wire logic [1:0] counter_active,
   input wire logic [1:0] logic_block_out,
   input wire logic exposure_active,
   input wire logic ready_for_frame_trigger,
   // soft outputs for internal use
   output logic [3:0] soft_output_vector
);

   typedef struct packed {
      logic [1:0] line_picker;
      logic [3:0] line_direction;
      logic [3:0] line_polarity_flip;
      logic [3:0] aux_rail;
      logic [3:0][2:0] line_drive_origin;
      logic [3:0][1:0] origin_sub;
      logic input_filter_choice;
      logic [3:0][1:0][15:0] filter_span_us;
      logic [1:0] soft_output_picker;
      logic [3:0] soft_bits;
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic [3:0] dg_level;
      logic [3:0][23:0] dg_cnt;
      logic [3:0] db_level;
      logic [3:0][23:0] db_cnt;
      logic [3:0] drive;
      logic [31:0] rdata;
      logic rerr;
   } gfl_state_t;

   gfl_state_t st_r;
   gfl_state_t st_nxt;

   // cycle widths derived from the microsecond spans
   logic [3:0][23:0] dg_width;
   logic [3:0][23:0] db_width;
   logic [3:0] level;
   logic [3:0] src;
   logic [7:0] off;
   logic setup;
   logic wr_acc;

   assign off = paddr[7:0];
   assign setup = psel & ~penable;
   assign wr_acc = psel & penable & pwrite;

   // microseconds times clock rate, 16 x 8 bits fits in 24
   always_comb begin
      for (int i = 0; i < gfl_pkg::NLINES; i++) begin
         dg_width[i] = 24'({8'h00, st_r.filter_span_us[i][0]} * gfl_pkg::CYC_PER_US);
         db_width[i] = 24'({8'h00, st_r.filter_span_us[i][1]} * gfl_pkg::CYC_PER_US);
      end
   end

   // level seen on each line: driven value when output, filtered pin otherwise
   always_comb begin
      for (int i = 0; i < gfl_pkg::NLINES; i++) begin
         if (st_r.line_direction[i]) begin
            level[i] = st_r.drive[i];
         end else begin
            level[i] = st_r.db_level[i] ^ st_r.line_polarity_flip[i];
         end
      end
   end

   // drive source pick per line
   always_comb begin
      for (int i = 0; i < gfl_pkg::NLINES; i++) begin
         case (gfl_pkg::gfl_origin_t'(st_r.line_drive_origin[i]))
            gfl_pkg::ORG_LOOPBACK: src[i] = level[st_r.origin_sub[i]];
            gfl_pkg::ORG_SOFT: src[i] = st_r.soft_bits[st_r.origin_sub[i]];
            gfl_pkg::ORG_COUNTER: src[i] = counter_active[st_r.origin_sub[i][0]];
            gfl_pkg::ORG_LOGIC: src[i] = logic_block_out[st_r.origin_sub[i][0]];
            gfl_pkg::ORG_EXPOSURE: src[i] = exposure_active;
            gfl_pkg::ORG_FRAME_WAIT: src[i] = ready_for_frame_trigger;
            default: src[i] = 1'b0;
         endcase
      end
   end

   // next state: sync, filters, drive, register writes, read capture
   always_comb begin
      st_nxt = st_r;
      // pins pass two flops before any logic
      st_nxt.sync1 = line_in;
      st_nxt.sync2 = st_r.sync1;
      for (int i = 0; i < gfl_pkg::NLINES; i++) begin
         // deglitch: level must hold for the full width
         if (st_r.sync2[i] == st_r.dg_level[i]) begin
            st_nxt.dg_cnt[i] = 24'h000000;
         end else if (st_r.dg_cnt[i] + 24'h000001 >= dg_width[i]) begin
            st_nxt.dg_level[i] = st_r.sync2[i];
            st_nxt.dg_cnt[i] = 24'h000000;
         end else begin
            st_nxt.dg_cnt[i] = st_r.dg_cnt[i] + 24'h000001;
         end
         // debounce fed by deglitch: first edge passes, then a hold-off
         if (st_r.db_cnt[i] != 24'h000000) begin
            st_nxt.db_cnt[i] = st_r.db_cnt[i] - 24'h000001;
         end else if (st_r.dg_level[i] != st_r.db_level[i]) begin
            st_nxt.db_level[i] = st_r.dg_level[i];
            st_nxt.db_cnt[i] = db_width[i];
         end
         // registered drive breaks loops between loopback lines
         st_nxt.drive[i] = src[i] ^ st_r.line_polarity_flip[i];
      end

      // writes take effect at the access edge
      if (wr_acc) begin
         case (off)
            gfl_pkg::OFF_LINE_PICKER: st_nxt.line_picker = pwdata[1:0];
            gfl_pkg::OFF_LINE_CFG: begin
               st_nxt.line_direction[st_r.line_picker] = pwdata[gfl_pkg::F_DIR];
               st_nxt.line_polarity_flip[st_r.line_picker] = pwdata[gfl_pkg::F_FLIP];
               st_nxt.aux_rail[st_r.line_picker] = pwdata[gfl_pkg::F_AUX];
               st_nxt.line_drive_origin[st_r.line_picker] =
                  pwdata[gfl_pkg::F_ORIGIN_LO +: 3];
               st_nxt.origin_sub[st_r.line_picker] = pwdata[gfl_pkg::F_SUB_LO +: 2];
            end
            gfl_pkg::OFF_FILTER_CHOICE: st_nxt.input_filter_choice = pwdata[0];
            gfl_pkg::OFF_FILTER_SPAN: begin
               st_nxt.filter_span_us[st_r.line_picker][st_r.input_filter_choice] =
                  pwdata[15:0];
            end
            gfl_pkg::OFF_SOFT_PICKER: st_nxt.soft_output_picker = pwdata[1:0];
            gfl_pkg::OFF_SOFT_LEVEL: st_nxt.soft_bits[st_r.soft_output_picker] = pwdata[0];
            gfl_pkg::OFF_SOFT_VECTOR: st_nxt.soft_bits = pwdata[3:0];
            default: st_nxt.soft_bits = st_r.soft_bits; // read-only or unmapped
         endcase
      end

      // read data and error captured in setup, held through access
      if (setup) begin
         st_nxt.rdata = 32'h00000000;
         st_nxt.rerr = 1'b0;
         case (off)
            gfl_pkg::OFF_LINE_PICKER: st_nxt.rdata[1:0] = st_r.line_picker;
            gfl_pkg::OFF_LINE_CFG: begin
               st_nxt.rdata[gfl_pkg::F_DIR] = st_r.line_direction[st_r.line_picker];
               st_nxt.rdata[gfl_pkg::F_FLIP] = st_r.line_polarity_flip[st_r.line_picker];
               st_nxt.rdata[gfl_pkg::F_AUX] = st_r.aux_rail[st_r.line_picker];
               st_nxt.rdata[gfl_pkg::F_ORIGIN_LO +: 3] = st_r.line_drive_origin[st_r.line_picker];
               st_nxt.rdata[gfl_pkg::F_SUB_LO +: 2] = st_r.origin_sub[st_r.line_picker];
            end
            gfl_pkg::OFF_LINE_STAT: begin
               st_nxt.rdata[gfl_pkg::F_LEVEL] = level[st_r.line_picker];
               st_nxt.rdata[gfl_pkg::F_CIRCUIT_LO +: 2] =
                  gfl_pkg::CIRCUIT_MAP[{st_r.line_picker, 1'b0} +: 2];
            end
            gfl_pkg::OFF_ALL_LINES: st_nxt.rdata[3:0] = level;
            gfl_pkg::OFF_FILTER_CHOICE: st_nxt.rdata[0] = st_r.input_filter_choice;
            gfl_pkg::OFF_FILTER_SPAN: begin
               st_nxt.rdata[15:0] =
                  st_r.filter_span_us[st_r.line_picker][st_r.input_filter_choice];
            end
            gfl_pkg::OFF_SOFT_PICKER: st_nxt.rdata[1:0] = st_r.soft_output_picker;
            gfl_pkg::OFF_SOFT_LEVEL: st_nxt.rdata[0] = st_r.soft_bits[st_r.soft_output_picker];
            gfl_pkg::OFF_SOFT_VECTOR: st_nxt.rdata[3:0] = st_r.soft_bits;
            default: st_nxt.rerr = 1'b1; // unmapped address
         endcase
      end
   end

   // single state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
         for (int i = 0; i < gfl_pkg::NLINES; i++) begin
            st_r.line_drive_origin[i] <= gfl_pkg::ORIGIN_RST;
            st_r.filter_span_us[i][0] <= gfl_pkg::SPAN_RST;
            st_r.filter_span_us[i][1] <= gfl_pkg::SPAN_RST;
         end
      end else begin
         st_r <= st_nxt;
      end
   end

   // apb answer: zero wait, data settled since setup
   assign pready = 1'b1;
   assign prdata = st_r.rdata;
   assign pslverr = st_r.rerr & psel & penable;

   // pins: enable only in output direction; rail only where fitted
   assign line_out = st_r.drive & st_r.line_direction;
   assign line_oe = st_r.line_direction;
   assign aux_rail_switch = st_r.aux_rail & gfl_pkg::AUX_CAPABLE;
   assign soft_output_vector = st_r.soft_bits;

endmodule : gfl_gpio

//--- test/gfl_pins.sv
/* gfl_pins: external circuit on the four connector lines.
   assumes ext_drv comes from the bench and stands for the far driver. */
`timescale 1ns/1ps
module gfl_pins (
   // from the block and the bench
   input wire logic [3:0] line_out,
   input wire logic [3:0] line_oe,
   input wire logic [3:0] ext_drv,
   // back to the block
   output logic [3:0] line_in
);
   // a driven line shows the block, an undriven one the far circuit
   assign line_in = (line_oe & line_out) | (~line_oe & ext_drv);
endmodule : gfl_pins

//--- test/gfl_sva.sv
/* gfl_sva: port checks of the four-line block.
   assumes a bind onto gfl_gpio, one pclk domain. */
`timescale 1ns/1ps
module gfl_sva (
   // clock, reset, apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // lines and soft bits
   input wire logic [3:0] line_out,
   input wire logic [3:0] line_oe,
   input wire logic [3:0] aux_rail_switch,
   input wire logic [3:0] soft_output_vector
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   logic cfg_d1;
   logic cfg_d2;
   // config reaches the pins one flop after the write; a change one cycle later is allowed too
   assign acc = psel && penable;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_d1 <= 1'b0;
         cfg_d2 <= 1'b0;
      end else begin
         cfg_d1 <= acc && pwrite && paddr[7:0] == 8'h04;
         cfg_d2 <= cfg_d1;
      end
   end
   input_undriven_a: assert property ((line_out & ~line_oe) == 4'h0) else $error("input line driven");
   dir_by_cfg_a: assert property ($changed(line_oe) |-> cfg_d1 || cfg_d2) else $error("oe moved");
   aux_lines_a: assert property ((aux_rail_switch & 4'hb) == 4'h0) else $error("aux on bad line");
   aux_by_cfg_a: assert property ($changed(aux_rail_switch) |-> cfg_d1 || cfg_d2) else $error("aux moved");
   soft_by_wr_a: assert property ($changed(soft_output_vector) |->
      $past(acc && pwrite && (paddr[7:0] == 8'h1c || paddr[7:0] == 8'h20))) else $error("soft moved");
   soft_vec_load_a: assert property (acc && pwrite && paddr[7:0] == 8'h20 |=>
      soft_output_vector == $past(pwdata[3:0])) else $error("soft vector load");
   levels_width_a: assert property (acc && !pwrite && paddr[7:0] == 8'h0c |->
      prdata[31:4] == 28'h0) else $error("level vector width");
   circuit_code_a: assert property (acc && !pwrite && paddr[7:0] == 8'h08 |->
      prdata[31:3] == 29'h0 && prdata[2:1] != 2'h3) else $error("circuit code");
endmodule : gfl_sva

//--- test/tb_top.sv
/* tb_top: apb sequences against the four-line block and pin model.
   assumes gfl_pkg, gfl_gpio, gfl_pins and gfl_sva compiled first. */
`timescale 1ns/1ps
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [31:0] paddr, pwdata, prdata, q;
   logic [3:0] line_in, line_out, line_oe, aux_rail_switch, soft_output_vector, ext_drv;
   logic [5:0] src;
   int miscompares, checks, k;
   gfl_gpio uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .aux_rail_switch(aux_rail_switch),
      .counter_active(src[1:0]), .logic_block_out(src[3:2]), .exposure_active(src[4]),
      .ready_for_frame_trigger(src[5]), .soft_output_vector(soft_output_vector));
   gfl_pins pins (.line_out(line_out), .line_oe(line_oe), .ext_drv(ext_drv), .line_in(line_in));
   // 4 ns period
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task automatic test_done;
      if (miscompares == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // one transfer, held until pready is seen; a lost answer ends the run
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16) begin
         miscompares++;
         test_done();
      end
   endtask : apb
   task automatic rdc(string name, logic [7:0] a, logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(name, exp, q);
   endtask : rdc
   task automatic wt(int n);
      repeat (n) @(posedge pclk);
   endtask : wt
   initial begin
      logic [2:0] org [4] = '{3'h2, 3'h3, 3'h4, 3'h5};
      int sbit [4] = '{0, 2, 4, 5};
      {presetn, psel, penable, pwrite, paddr, pwdata, ext_drv, src} = '0;
      wt(20);
      presetn <= 1'b1;
      rdc("cfg", gfl_pkg::OFF_LINE_CFG, 32'h10);
      // deglitch 1 us: a short pulse is lost, a held level arrives late
      apb(1'b1, gfl_pkg::OFF_FILTER_SPAN, 32'h1);
      ext_drv <= 4'h1;
      wt(100);
      ext_drv <= 4'h0;
      wt(300);
      rdc("pulse", gfl_pkg::OFF_ALL_LINES, 32'h0);
      ext_drv <= 4'h1;
      wt(200);
      rdc("early", gfl_pkg::OFF_ALL_LINES, 32'h0);
      wt(100);
      rdc("level", gfl_pkg::OFF_LINE_STAT, 32'h1);
      // debounce 1 us: first edge passes, the next is held off
      apb(1'b1, gfl_pkg::OFF_FILTER_SPAN, 32'h0);
      apb(1'b1, gfl_pkg::OFF_FILTER_CHOICE, 32'h1);
      apb(1'b1, gfl_pkg::OFF_FILTER_SPAN, 32'h1);
      ext_drv <= 4'h0;
      wt(8);
      rdc("first", gfl_pkg::OFF_ALL_LINES, 32'h0);
      ext_drv <= 4'h1;
      wt(100);
      rdc("blocked", gfl_pkg::OFF_ALL_LINES, 32'h0);
      wt(250);
      rdc("freed", gfl_pkg::OFF_ALL_LINES, 32'h1);
      apb(1'b1, gfl_pkg::OFF_ALL_LINES, 32'hf);
      rdc("ro", gfl_pkg::OFF_ALL_LINES, 32'h1);
      // line 1 as output from soft bit 0
      apb(1'b1, gfl_pkg::OFF_LINE_PICKER, 32'h1);
      apb(1'b1, gfl_pkg::OFF_LINE_CFG, 32'h11);
      apb(1'b1, gfl_pkg::OFF_SOFT_VECTOR, 32'h1);
      wt(3);
      chk("drive", 32'h22, {24'h0, line_oe, line_out});
      apb(1'b1, gfl_pkg::OFF_LINE_CFG, 32'h13);
      wt(3);
      chk("flip", 32'h20, {24'h0, line_oe, line_out});
      apb(1'b1, gfl_pkg::OFF_SOFT_PICKER, 32'h2);
      apb(1'b1, gfl_pkg::OFF_SOFT_LEVEL, 32'h1);
      rdc("soft", gfl_pkg::OFF_SOFT_VECTOR, 32'h5);
      chk("soft port", 32'h5, {28'h0, soft_output_vector});
      // counter 0, logic 0, exposure and frame-wait sources each alone high, then alone low with the rest high
      for (k = 0; k < 4; k++) begin
         apb(1'b1, gfl_pkg::OFF_LINE_CFG, {25'h0, org[k], 4'h1});
         src <= 6'h1 << sbit[k];
         wt(3);
         chk("src on", 32'h2, {28'h0, line_out});
         src <= 6'h3f ^ (6'h1 << sbit[k]);
         wt(3);
         chk("src off", 32'h0, {28'h0, line_out});
      end
      src <= 6'h0;
      apb(1'b1, gfl_pkg::OFF_LINE_CFG, 32'h01);
      wt(3);
      chk("loop", 32'h2, {28'h0, line_out});
      for (k = 0; k < 4; k++) begin
         apb(1'b1, gfl_pkg::OFF_LINE_PICKER, k);
         apb(1'b1, gfl_pkg::OFF_LINE_CFG, 32'h14);
         // a line just turned to input still shows its old drive until sync and filters catch up
         wt(8);
         rdc("circuit", gfl_pkg::OFF_LINE_STAT, {29'h0, gfl_pkg::CIRCUIT_MAP[2 * k +: 2], k == 0});
      end
      chk("aux", {28'h0, gfl_pkg::AUX_CAPABLE}, {28'h0, aux_rail_switch});
      chk("idle", 32'h0, {24'h0, line_oe, line_out});
      rdc("unmapped", 8'h24, 32'h0);
      chk("slverr", 32'h1, {31'h0, e});
      test_done();
   end
endmodule : tb_top
bind gfl_gpio gfl_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .line_out(line_out),
   .line_oe(line_oe), .aux_rail_switch(aux_rail_switch), .soft_output_vector(soft_output_vector));
